// >>> core/hlef_evt_if.sv
`timescale 1ns/10ps
`default_nettype none
// event set / clear-on-access / flag state between controller and bank
interface hlef_evt_if #(parameter int N = 5);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] flags;
  modport bank(input set, input clr, output flags);
  modport ctrl(output set, output clr, input flags);
endinterface
`default_nettype wire

// >>> core/hlef_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none
module hlef_flag_bank
  import hlef_pkg::*;
#(
  parameter int N = NUM_FLAGS
) (
  input wire logic aclk,
  input wire logic aresetn,
  hlef_evt_if.bank ev
);

  // ----------------------------------------------------------------
  // sticky flags, a set in the clearing cycle wins
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_flag
      logic flag_ff;
      logic nxt_flag;

      // next value: set dominates clear
      always_comb begin
        nxt_flag = ev.set[gi] | (flag_ff & ~ev.clr[gi]);
      end

      // register the flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flag_ff <= 1'b0;
        end else begin
          flag_ff <= nxt_flag;
        end
      end

      assign ev.flags[gi] = flag_ff;

      set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ev.set[gi] |=> flag_ff)
        else $error("flag lost an event that met its clear");

      clear_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ev.clr[gi] && !ev.set[gi]) |=> !flag_ff)
        else $error("flag survived a clear without a new event");
    end
  endgenerate

endmodule
`default_nettype wire

// >>> core/hlef_pkg.sv
package hlef_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 16;
  localparam int AXI_DATA_W = 32;
  localparam int IDX_W = AXI_ADDR_W - 2;
  localparam int REG_W = 8;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CTL2_FLAG = 14'h0b18;
  localparam logic [IDX_W-1:0] IDX_CTL2_EN = 14'h0b19;
  localparam logic [IDX_W-1:0] IDX_CTL3_STAT = 14'h0b26;
  localparam logic [IDX_W-1:0] IDX_CTL3_EN = 14'h0b27;

  // ----------------------------------------------------------------
  // bit positions inside the 8-bit registers
  // ----------------------------------------------------------------
  localparam int BIT_OVS = 0;
  localparam int BIT_KIND = 7;
  localparam int BIT_TXB = 6;
  localparam int BIT_RXB = 5;
  localparam int BIT_TXD = 4;
  localparam int BIT_RXD = 3;

  // ----------------------------------------------------------------
  // flag bank slots
  // ----------------------------------------------------------------
  localparam int NUM_FLAGS = 5;
  localparam int FL_OVS = 0;
  localparam int FL_RXD = 1;
  localparam int FL_TXD = 2;
  localparam int FL_RXB = 3;
  localparam int FL_TXB = 4;

  // ----------------------------------------------------------------
  // message size, responses, reset values
  // ----------------------------------------------------------------
  localparam int MSG_BYTE_LIMIT = 276;
  localparam int BYTE_CNT_W = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [REG_W-1:0] RST_REG = 8'h00;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP = 2'b10
  } hlef_wr_state_type;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } hlef_rd_state_type;

endpackage

// >>> core/hlef_top.sv
//Behaviour
//- the controller-2 oversize flag sets once a received message passes 276 bytes.
//- that flag shows an event since the last read, and reading its register clears it.
//- the oversize event raises the interrupt only while its enable, reset to 0, is 1.
//- status bit 7 of controller 3 shows the kind of the last received message.
//- bit 6 sets when the transmitter starts sending a message.
//- bit 5 sets when the receiver starts receiving a message.
//- bit 4 sets when the transmitter finishes sending a message.
//- controller-3 event flags show an event since the last read and clear on read.
//- bit 3 sets when a message is fully received or the receive buffer is full.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module hlef_top
  import hlef_pkg::*;
#(
  parameter int MSG_LIMIT = MSG_BYTE_LIMIT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ctl2_rx_msg_start,
  input wire logic ctl2_rx_byte,
  input wire logic rx3_msg_begin,
  input wire logic rx3_msg_done,
  input wire logic rx3_buf_full,
  input wire logic rx3_msg_kind,
  input wire logic tx3_msg_begin,
  input wire logic tx3_msg_done,
  output logic irq
);

  hlef_evt_if #(.N(NUM_FLAGS)) ev ();

  hlef_flag_bank #(.N(NUM_FLAGS)) u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(ev.bank)
  );

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  hlef_wr_state_type wr_ff, nxt_wr;
  hlef_rd_state_type rd_ff, nxt_rd;
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [IDX_W-1:0] widx_ff, nxt_widx;
  logic [REG_W-1:0] wbyte_ff, nxt_wbyte;
  logic wlane_ff, nxt_wlane;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [REG_W-1:0] rdata_ff, nxt_rdata;
  logic do_write, ar_hs;
  logic [IDX_W-1:0] ridx;
  logic [NUM_FLAGS-1:0] wr_clr, rd_clr, en_vec;
  logic ctl2_en_ff, nxt_ctl2_en;
  logic [REG_W-1:0] ctl3_en_ff, nxt_ctl3_en;
  logic kind_ff, nxt_kind;
  logic [BYTE_CNT_W-1:0] byte_cnt_ff, nxt_byte_cnt;
  logic irq_ff, nxt_irq;

  // ----------------------------------------------------------------
  // controller-2 message length watch
  // ----------------------------------------------------------------

  // count bytes of the current message, saturating past the limit
  always_comb begin
    nxt_byte_cnt = byte_cnt_ff;
    if (ctl2_rx_msg_start) begin
      nxt_byte_cnt = ctl2_rx_byte ? BYTE_CNT_W'(1) : '0;
    end else if (ctl2_rx_byte && (byte_cnt_ff <= BYTE_CNT_W'(MSG_LIMIT))) begin
      nxt_byte_cnt = byte_cnt_ff + BYTE_CNT_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_cnt_ff <= '0;
    end else begin
      byte_cnt_ff <= nxt_byte_cnt;
    end
  end

  // ----------------------------------------------------------------
  // event sources into the flag bank
  // ----------------------------------------------------------------
  assign ev.set[FL_OVS] = ctl2_rx_byte && !ctl2_rx_msg_start
                          && (byte_cnt_ff == BYTE_CNT_W'(MSG_LIMIT));
  assign ev.set[FL_TXB] = tx3_msg_begin;
  assign ev.set[FL_RXB] = rx3_msg_begin;
  assign ev.set[FL_TXD] = tx3_msg_done;
  assign ev.set[FL_RXD] = rx3_msg_done | rx3_buf_full;
  assign ev.clr = wr_clr | rd_clr;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------

  // collect address and data in either order, then answer
  always_comb begin
    nxt_wr = wr_ff;
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_widx = widx_ff;
    nxt_wbyte = wbyte_ff;
    nxt_wlane = wlane_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    do_write = 1'b0;
    case (wr_ff)
      WR_COLLECT: begin
        if (awvalid && awready_ff) begin
          nxt_aw_got = 1'b1;
          nxt_widx = awaddr[AXI_ADDR_W-1:2];
        end
        if (wvalid && wready_ff) begin
          nxt_w_got = 1'b1;
          nxt_wbyte = wdata[REG_W-1:0];
          nxt_wlane = wstrb[0];
        end
        if (aw_got_ff && w_got_ff) begin
          do_write = 1'b1;
          nxt_aw_got = 1'b0;
          nxt_w_got = 1'b0;
          nxt_bvalid = 1'b1;
          nxt_wr = WR_RESP;
          if ((widx_ff == IDX_CTL2_FLAG) || (widx_ff == IDX_CTL2_EN)
              || (widx_ff == IDX_CTL3_STAT) || (widx_ff == IDX_CTL3_EN)) begin
            nxt_bresp = RESP_OKAY;
          end else begin
            nxt_bresp = RESP_SLVERR;
          end
        end
      end
      WR_RESP: begin
        if (bready) begin
          nxt_bvalid = 1'b0;
          nxt_wr = WR_COLLECT;
        end
      end
      default: begin
        nxt_wr = WR_COLLECT;
      end
    endcase
    nxt_awready = (nxt_wr == WR_COLLECT) && !nxt_aw_got;
    nxt_wready = (nxt_wr == WR_COLLECT) && !nxt_w_got;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ff <= WR_COLLECT;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      widx_ff <= '0;
      wbyte_ff <= RST_REG;
      wlane_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      wr_ff <= nxt_wr;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      widx_ff <= nxt_widx;
      wbyte_ff <= nxt_wbyte;
      wlane_ff <= nxt_wlane;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // ----------------------------------------------------------------
  // register writes: enables, write-one-to-clear on status
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctl2_en = ctl2_en_ff;
    nxt_ctl3_en = ctl3_en_ff;
    wr_clr = '0;
    if (do_write && wlane_ff) begin
      if (widx_ff == IDX_CTL2_EN) begin
        nxt_ctl2_en = wbyte_ff[BIT_OVS];
      end else if (widx_ff == IDX_CTL3_EN) begin
        nxt_ctl3_en = wbyte_ff;
      end else if (widx_ff == IDX_CTL2_FLAG) begin
        wr_clr[FL_OVS] = wbyte_ff[BIT_OVS];
      end else if (widx_ff == IDX_CTL3_STAT) begin
        wr_clr[FL_TXB] = wbyte_ff[BIT_TXB];
        wr_clr[FL_RXB] = wbyte_ff[BIT_RXB];
        wr_clr[FL_TXD] = wbyte_ff[BIT_TXD];
        wr_clr[FL_RXD] = wbyte_ff[BIT_RXD];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl2_en_ff <= 1'b0;
      ctl3_en_ff <= RST_REG;
    end else begin
      ctl2_en_ff <= nxt_ctl2_en;
      ctl3_en_ff <= nxt_ctl3_en;
    end
  end

  // ----------------------------------------------------------------
  // read channel, reading a status register clears its flags
  // ----------------------------------------------------------------
  assign ar_hs = arvalid && arready_ff;
  assign ridx = araddr[AXI_ADDR_W-1:2];

  always_comb begin
    nxt_rd = rd_ff;
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    rd_clr = '0;
    case (rd_ff)
      RD_IDLE: begin
        if (ar_hs) begin
          nxt_rd = RD_RESP;
          nxt_arready = 1'b0;
          nxt_rvalid = 1'b1;
          nxt_rresp = RESP_OKAY;
          nxt_rdata = RST_REG;
          if (ridx == IDX_CTL2_FLAG) begin
            nxt_rdata[BIT_OVS] = ev.flags[FL_OVS];
            rd_clr[FL_OVS] = 1'b1;
          end else if (ridx == IDX_CTL2_EN) begin
            nxt_rdata[BIT_OVS] = ctl2_en_ff;
          end else if (ridx == IDX_CTL3_STAT) begin
            nxt_rdata[BIT_KIND] = kind_ff;
            nxt_rdata[BIT_TXB] = ev.flags[FL_TXB];
            nxt_rdata[BIT_RXB] = ev.flags[FL_RXB];
            nxt_rdata[BIT_TXD] = ev.flags[FL_TXD];
            nxt_rdata[BIT_RXD] = ev.flags[FL_RXD];
            rd_clr = '1;
            rd_clr[FL_OVS] = 1'b0;
          end else if (ridx == IDX_CTL3_EN) begin
            nxt_rdata[BIT_TXB:BIT_RXD] = ctl3_en_ff[BIT_TXB:BIT_RXD];
          end else begin
            nxt_rresp = RESP_SLVERR;
          end
        end
      end
      RD_RESP: begin
        if (rready) begin
          nxt_rd = RD_IDLE;
          nxt_rvalid = 1'b0;
          nxt_arready = 1'b1;
        end
      end
      default: begin
        nxt_rd = RD_IDLE;
        nxt_arready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ff <= RD_IDLE;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= RST_REG;
    end else begin
      rd_ff <= nxt_rd;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // message kind and interrupt output
  // ----------------------------------------------------------------
  assign en_vec[FL_OVS] = ctl2_en_ff;
  assign en_vec[FL_TXB] = ctl3_en_ff[BIT_TXB];
  assign en_vec[FL_RXB] = ctl3_en_ff[BIT_RXB];
  assign en_vec[FL_TXD] = ctl3_en_ff[BIT_TXD];
  assign en_vec[FL_RXD] = ctl3_en_ff[BIT_RXD];

  // latch kind at message end, combine enabled flags
  always_comb begin
    nxt_kind = rx3_msg_done ? rx3_msg_kind : kind_ff;
    nxt_irq = |(ev.flags & en_vec);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      kind_ff <= nxt_kind;
      irq_ff <= nxt_irq;
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = {{(AXI_DATA_W-REG_W){1'b0}}, rdata_ff};
  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  oversize_sets_a: assert property (
    (ctl2_rx_byte && !ctl2_rx_msg_start && byte_cnt_ff == BYTE_CNT_W'(MSG_LIMIT))
    |=> ev.flags[FL_OVS] ##0 byte_cnt_ff == BYTE_CNT_W'(MSG_LIMIT + 1))
    else $error("oversize flag missed the byte past the limit");

  oversize_read_a: assert property (
    (ar_hs && ridx == IDX_CTL2_FLAG && !ev.set[FL_OVS])
    |=> (rdata_ff[BIT_OVS] == $past(ev.flags[FL_OVS])) && !ev.flags[FL_OVS])
    else $error("oversize read returned a wrong value or did not clear");

  oversize_irq_a: assert property (
    (ev.flags[FL_OVS] && ctl2_en_ff) |=> irq_ff)
    else $error("enabled oversize flag gave no interrupt");

  kind_bit_a: assert property (
    rx3_msg_done ##1 (ar_hs && ridx == IDX_CTL3_STAT && !rx3_msg_done)
    |=> rdata_ff[BIT_KIND] == $past(rx3_msg_kind, 2))
    else $error("message kind bit does not follow the last message");

  tx_begin_a: assert property (tx3_msg_begin |=> ev.flags[FL_TXB])
    else $error("transmit start flag not set");

  rx_begin_a: assert property (rx3_msg_begin |=> ev.flags[FL_RXB])
    else $error("receive start flag not set");

  tx_done_a: assert property (tx3_msg_done |=> ev.flags[FL_TXD])
    else $error("transmit end flag not set");

  stat3_clear_a: assert property (
    (ar_hs && ridx == IDX_CTL3_STAT && !(|ev.set[FL_TXB:FL_RXD]))
    |=> !(|ev.flags[FL_TXB:FL_RXD]))
    else $error("status read did not clear controller-3 flags");

  rx_done_a: assert property ((rx3_msg_done || rx3_buf_full) |=> ev.flags[FL_RXD])
    else $error("receive end flag not set");

  irq_quiet_a: assert property (
    (!(|(ev.flags & en_vec)) && !(|ev.set)) [*2] |-> !irq_ff)
    else $error("interrupt high with no enabled flag");

  oversize_cov: cover property (ev.set[FL_OVS] ##[1:8] irq_ff);
  read_clear_cov: cover property (ar_hs && ridx == IDX_CTL3_STAT && |ev.flags);
  set_on_clear_cov: cover property (|(ev.set & ev.clr));
  write_en_cov: cover property (do_write && widx_ff == IDX_CTL3_EN);

endmodule
`default_nettype wire

// >>> sim/hlef_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module hlef_top_tb_top
  import hlef_pkg::*;
;
  // ----------------------------------------------------------------
  // clock, reset and design hookup
  // ----------------------------------------------------------------
  localparam int LIM = 4;
  localparam logic [15:0] A_F2 = {IDX_CTL2_FLAG, 2'b00};
  localparam logic [15:0] A_E2 = {IDX_CTL2_EN, 2'b00};
  localparam logic [15:0] A_S3 = {IDX_CTL3_STAT, 2'b00};
  localparam logic [15:0] A_E3 = {IDX_CTL3_EN, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [15:0] araddr = 16'h0000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [6:0] evt = 7'h00; // start, byte, rx begin, rx done, rx full, tx begin, tx done
  logic kind = 1'b0;
  logic irq;
  int n_errors = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h2ee1740e;
  logic exp_kind = 1'b0;

  // clock toggles every 25 ns, a period of 50 ns
  always #25 aclk = ~aclk;

  hlef_top #(.MSG_LIMIT(LIM)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ctl2_rx_msg_start(evt[0]), .ctl2_rx_byte(evt[1]),
    .rx3_msg_begin(evt[2]), .rx3_msg_done(evt[3]), .rx3_buf_full(evt[4]),
    .rx3_msg_kind(kind), .tx3_msg_begin(evt[5]), .tx3_msg_done(evt[6]),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // status bit that each controller-3 event should set
  function automatic logic [7:0] stat_mask(input int k);
    case (k)
      2: return 8'h20;
      3: return 8'h08;
      4: return 8'h08;
      5: return 8'h40;
      default: return 8'h10;
    endcase
  endfunction

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // one aw and one w offered together, response awaited
  task automatic axi_write(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'h3;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    if (k == 64) check(32'h1, 32'h0, "write response missing");
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    d = 32'hffff_ffff;
    r = 2'h3;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    if (k == 64) check(32'h1, 32'h0, "read response missing");
    rready <= 1'b0;
  endtask

  // event line i held high for n cycles (n pulses)
  task automatic pulse(input int i, input int n);
    @(posedge aclk);
    evt[i] <= 1'b1;
    repeat (n) @(posedge aclk);
    evt[i] <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(d, {24'h00_0000, e}, "read data");
    check({30'h0, r}, {30'h0, er}, "read response");
  endtask

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, {31'h0, e}, "irq level");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] r;
    logic [7:0] en;
    int k;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and unmapped space
    rd_chk(A_F2, 8'h00, RESP_OKAY);
    rd_chk(A_E2, 8'h00, RESP_OKAY);
    rd_chk(A_S3, 8'h00, RESP_OKAY);
    rd_chk(A_E3, 8'h00, RESP_OKAY);
    check({31'h0, irq}, 32'h0, "irq after reset");
    rd_chk(16'h0100, 8'h00, RESP_SLVERR);
    axi_write(16'h0104, 8'hff, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    // enable registers read back their implemented bits
    for (k = 0; k < 4; k++) begin
      seed = lfsr_next(seed);
      axi_write(A_E2, seed[7:0], r);
      rd_chk(A_E2, seed[7:0] & 8'h01, RESP_OKAY);
      axi_write(A_E3, seed[15:8], r);
      rd_chk(A_E3, seed[15:8] & 8'h78, RESP_OKAY);
    end
    axi_write(A_E2, 8'h00, r);
    // oversize: limit bytes are fine, one more sets the flag
    pulse(0, 1);
    pulse(1, LIM);
    rd_chk(A_F2, 8'h00, RESP_OKAY);
    pulse(1, 1);
    irq_chk(1'b0);
    axi_write(A_E2, 8'h01, r);
    irq_chk(1'b1);
    pulse(1, 2);
    rd_chk(A_F2, 8'h01, RESP_OKAY);
    rd_chk(A_F2, 8'h00, RESP_OKAY);
    irq_chk(1'b0);
    // a fresh message sets it again; write one clears it
    pulse(0, 1);
    pulse(1, LIM + 1);
    irq_chk(1'b1);
    axi_write(A_F2, 8'h01, r);
    irq_chk(1'b0);
    rd_chk(A_F2, 8'h00, RESP_OKAY);
    axi_write(A_E2, 8'h00, r);
    // controller 3: every event, both message kinds, random enables
    for (k = 0; k < 40; k++) begin
      int e;
      seed = lfsr_next(seed);
      e = (k < 5) ? k + 2 : 2 + int'(seed[2:0]) % 5;
      en = (k < 5) ? 8'h78 : seed[15:8] & 8'h78;
      axi_write(A_E3, en, r);
      @(posedge aclk);
      kind <= seed[20];
      if (e == 3) exp_kind = seed[20];
      pulse(e, 1);
      irq_chk(|(en & stat_mask(e)));
      rd_chk(A_S3, {exp_kind, 7'h00} | stat_mask(e), RESP_OKAY);
      rd_chk(A_S3, {exp_kind, 7'h00}, RESP_OKAY);
      irq_chk(1'b0);
    end
    // receive end followed at once by a status read, kind must follow
    kind <= 1'b1;
    exp_kind = 1'b1;
    fork
      pulse(3, 1);
      begin
        @(posedge aclk);
        rd_chk(A_S3, 8'h88, RESP_OKAY);
      end
    join
    // software reacts to transmit start, then clears that flag
    pulse(5, 1);
    axi_write(A_S3, 8'h40, r);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "status clear write");
    // next buffer loaded before transmit end, which meets a status read
    fork
      pulse(6, 1);
      rd_chk(A_S3, 8'h80, RESP_OKAY);
    join
    rd_chk(A_S3, 8'h90, RESP_OKAY);
    rd_chk(A_S3, 8'h80, RESP_OKAY);
    close_out();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
